/* src/dsrr_device.sv */
// Drive end: decodes requests and streams end-of-data replies.
// Operation
// - Read request: length 16, type 1h, fields.
// - Requester asks at most 64 bytes.
// - Read reply: type 3h, length 4N, words.
// - Channel in byte 3, reply echoes it.
// - Checksum in bytes 4-7, each sender.
// - Status request: length 5h, page byte 12.
// - Page 0 connect, 1 display, 2 statistics.
// - Page 1: length 16h, type 3h layout.
// - Page version byte 8 reads 0.
// - Cartridge byte flags in bits 7 to 2.
// - Cleaning byte 01h when needed, else 00h.
// - Bytes 12-27 display text, null byte 28.
// - Byte 30 holds thermistor temperature.
// - Library keeps symbol limits, checks index.
// - Symbol address is base plus 4 times index.
// - Symbol fetched by four-byte read request.
// - Eject mail: task E9, link 48, value.
// - Eject done: reply length 10, type 03.
// - Mail fields follow function, from byte 12.
`timescale 1ns/10ps
module dsrr_device
  import dsrr_pkg::*;
#(
  parameter int MAX_BYTES = MAX_READ_BYTES
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  dsrr_link_if.dev LNK,
  output logic MEM_RD,
  output logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_RDATA,
  input wire logic [5:0] CART_FLAGS,
  input wire logic CLEAN_NEEDED,
  input wire logic [127:0] DISPLAY_TEXT,
  input wire logic [7:0] TEMPERATURE,
  output logic MAIL_REQ,
  output logic [31:0] MAIL_TASK,
  output logic [31:0] MAIL_CMD,
  output logic [31:0] MAIL_LINK,
  output logic [31:0] MAIL_PARAM,
  output logic [31:0] MAIL_ITER,
  output logic [31:0] MAIL_EXPECT,
  input wire logic MAIL_DONE,
  input wire logic [31:0] MAIL_STATUS,
  input wire logic [31:0] MAIL_ITER_OK,
  output logic BAD_REQ
);
  // The reply store holds at most sixteen data words.
  if (MAX_BYTES < 4 || MAX_BYTES > (TX_WORDS - HDR_WORDS) * 4)
  begin : g_bad_max
    $error("MAX_BYTES does not fit the reply store.");
  end

  typedef enum logic [2:0] {
    S_RECV = 3'b000,
    S_DECODE = 3'b001,
    S_MEM = 3'b010,
    S_MAIL = 3'b011,
    S_FIN = 3'b100,
    S_SEND = 3'b101
  } dsrr_dev_state_e;

  dsrr_dev_state_e state;
  logic [31:0] rxw [RX_WORDS];
  logic [31:0] txw [TX_WORDS];
  logic [5:0] ri;
  logic [31:0] rsum;
  logic [31:0] tsum;
  logic [6:0] ntx;
  logic [6:0] ti;
  logic [7:0] rlen;
  logic [4:0] nw;
  logic [4:0] k;
  logic [1:0] mph;
  logic [31:0] p1 [6];
  logic [31:0] p1_sum;

  // Receive side: bytes are packed into words as they arrive.
  wire logic rx_fire = LNK.req_valid && LNK.req_ready;
  wire logic rx_in = rx_fire && (ri < 6'(RX_BYTES));
  wire logic [3:0] rwi = ri[5:2];
  wire logic [31:0] rx_word = {ri[1:0] == 2'd0 ? 24'h0 : rxw[rwi][23:0],
      LNK.req_data};
  wire logic [31:0] rx_pad = LNK.req_last ?
      rx_word << {~ri[1:0], 3'b000} : rx_word;
  wire logic buf_in_ready;
  assign LNK.req_ready = (state == S_RECV);

  // Decode of a received request.
  wire logic [31:0] fn = rxw[W_FUNC];
  wire logic [31:0] count = rxw[W_COUNT];
  wire logic [7:0] page = rxw[W_ARG][31:24];
  wire logic [7:0] chan = rxw[W_HDR][7:0];
  wire logic [7:0] cnt_up = {1'b0, count[6:0]} + 8'h03;
  wire logic pkt_ok = (rsum == rxw[W_SUM]) &&
      (rxw[W_HDR][15:8] == TYPE_REQUEST);
  wire logic dec = (state == S_DECODE) && pkt_ok;
  wire logic too_big = count > 32'(MAX_BYTES);
  wire logic is_read = (fn == MEMORY_BLOCK_READ_FUNCTION);
  wire logic is_stat = (fn == STATUS_PAGE_FUNCTION);
  wire logic go_read = dec && is_read && !too_big;
  wire logic go_p1 = dec && is_stat && (page == PAGE_DISPLAY);
  wire logic go_pempty = dec && is_stat &&
      (page == PAGE_CONNECT || page == PAGE_STATS);
  wire logic go_mail = dec && (fn == TASK_SCHEDULE_FUNCTION);
  wire logic go_bad = dec && !(go_read || go_p1 || go_pempty || go_mail);
  wire logic mem_cap = (state == S_MEM) && (mph == 2'd2);
  wire logic mail_fin = (state == S_MAIL) && MAIL_DONE;
  wire logic [31:0] hdr = hdr_word(rlen, END_OF_REPLY_TYPE, chan);
  wire logic [31:0] mail_sum = MAIL_STATUS + rxw[W_LINK] +
      rxw[W_PARAM] + MAIL_ITER_OK;

  // Mail fields are presented straight from the request words.
  assign MAIL_TASK = rxw[W_ARG];
  assign MAIL_CMD = rxw[W_COUNT];
  assign MAIL_LINK = rxw[W_LINK];
  assign MAIL_PARAM = rxw[W_PARAM];
  assign MAIL_ITER = rxw[W_ITER];
  assign MAIL_EXPECT = rxw[W_EXPECT];

  // Page 1 contents, sampled when the status request is decoded.
  assign p1[0] = {PAGE1_VERSION, 8'h00, CART_FLAGS, 2'b00,
      CLEAN_NEEDED ? CLEAN_NEEDED_CODE : CLEAN_IDLE_CODE};
  for (genvar g = 0; g < 4; g++) begin : g_text
    assign p1[1 + g] = DISPLAY_TEXT[127 - 32 * g -: 32];
  end
  assign p1[5] = {8'h00, 8'h00, TEMPERATURE, 8'h00};

  // Page 1 word sum, so the checksum is ready before streaming.
  always_comb begin
    p1_sum = '0;
    for (int i = 0; i < 6; i++) begin
      p1_sum = p1_sum + p1[i];
    end
  end

  // Control: request decode, memory fetch, mail wait and streaming.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state <= S_RECV;
      ri <= '0;
      rsum <= '0;
      tsum <= '0;
      ntx <= '0;
      ti <= '0;
      rlen <= '0;
      nw <= '0;
      k <= '0;
      mph <= '0;
      MEM_RD <= 1'b0;
      MEM_ADDR <= '0;
      MAIL_REQ <= 1'b0;
      BAD_REQ <= 1'b0;
    end else begin
      MAIL_REQ <= 1'b0;
      BAD_REQ <= 1'b0;
      unique case (state)
        S_RECV: begin
          if (rx_in && (ri[1:0] == 2'd3 || LNK.req_last) &&
              rwi != 4'(W_SUM)) begin
            rsum <= rsum + rx_pad;
          end
          if (rx_fire && ri < 6'd63) ri <= ri + 6'd1;
          if (rx_fire && LNK.req_last) state <= S_DECODE;
        end
        S_DECODE: begin
          ri <= '0;
          rsum <= '0;
          tsum <= '0;
          k <= '0;
          mph <= '0;
          if (!pkt_ok) begin
            state <= S_RECV;
          end else if (go_read) begin
            nw <= cnt_up[6:2];
            rlen <= {1'b0, cnt_up[6:2], 2'b00};
            ntx <= HDR_BYTES + {cnt_up[6:2], 2'b00};
            state <= S_MEM;
          end else if (go_p1) begin
            tsum <= p1_sum;
            rlen <= LEN_PAGE1;
            ntx <= PAGE1_BYTES;
            state <= S_FIN;
          end else if (go_pempty) begin
            rlen <= LEN_EMPTY;
            ntx <= HDR_BYTES;
            state <= S_FIN;
          end else if (go_mail) begin
            MAIL_REQ <= 1'b1;
            state <= S_MAIL;
          end else begin
            BAD_REQ <= go_bad;
            state <= S_RECV;
          end
        end
        S_MEM: begin
          unique case (mph)
            2'd0: begin
              if (k == nw) begin
                state <= S_FIN;
              end else begin
                MEM_RD <= 1'b1;
                MEM_ADDR <= rxw[W_ARG] + {25'h0, k, 2'b00};
                mph <= 2'd1;
              end
            end
            2'd1: begin
              MEM_RD <= 1'b0;
              mph <= 2'd2;
            end
            default: begin
              tsum <= tsum + MEM_RDATA;
              k <= k + 5'd1;
              mph <= 2'd0;
            end
          endcase
        end
        S_MAIL: begin
          if (MAIL_DONE) begin
            tsum <= mail_sum;
            rlen <= LEN_MAIL_REPLY;
            ntx <= MAIL_RPL_BYTES;
            state <= S_FIN;
          end
        end
        S_FIN: begin
          ti <= '0;
          state <= S_SEND;
        end
        S_SEND: begin
          if (buf_in_ready) begin
            ti <= ti + 7'd1;
            if (ti == ntx - 7'd1) state <= S_RECV;
          end
        end
        default: state <= S_RECV;
      endcase
    end
  end

  // Packet words; the header and checksum are written last.
  always_ff @(posedge CLK_SYS) begin
    if (rx_in) begin
      rxw[rwi] <= rx_pad;
    end
    if (go_p1) begin
      for (int i = 0; i < 6; i++) begin
        txw[HDR_WORDS + i] <= p1[i];
      end
    end
    if (mem_cap) txw[HDR_WORDS + int'(k)] <= MEM_RDATA;
    if (mail_fin) begin
      txw[2] <= MAIL_STATUS;
      txw[3] <= rxw[W_LINK];
      txw[4] <= rxw[W_PARAM];
      txw[5] <= MAIL_ITER_OK;
    end
    if (state == S_FIN) begin
      txw[W_HDR] <= hdr;
      txw[W_SUM] <= tsum + hdr;
    end
  end

  // Reply bytes pass a two-entry buffer so a link stall loses nothing.
  wire logic [7:0] tx_byte = pick_byte(txw[ti[6:2]], ti[1:0]);
  wire logic tx_last = (ti == ntx - 7'd1);
  wire logic [8:0] buf_out;
  assign LNK.rpl_data = buf_out[7:0];
  assign LNK.rpl_last = buf_out[8];

  dsrr_fifo #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_reply_buf (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(state == S_SEND),
    .in_ready(buf_in_ready),
    .in_data({tx_last, tx_byte}),
    .out_valid(LNK.rpl_valid),
    .out_ready(LNK.rpl_ready),
    .out_data(buf_out)
  );
endmodule : dsrr_device

/* src/dsrr_pkg.sv */
// Constants shared by both ends of the serial request/reply link.
package dsrr_pkg;
  // Packet types and request function indices.
  localparam logic [7:0] TYPE_REQUEST = 8'h01;
  localparam logic [7:0] END_OF_REPLY_TYPE = 8'h03;
  localparam logic [31:0] MEMORY_BLOCK_READ_FUNCTION = 32'h0000_0006;
  localparam logic [31:0] TASK_SCHEDULE_FUNCTION = 32'h0000_0008;
  localparam logic [31:0] STATUS_PAGE_FUNCTION = 32'h0000_0016;
  // Length bytes carried in byte 0.
  localparam logic [7:0] LEN_READ_REQ = 8'h10;
  localparam logic [7:0] LEN_STATUS_REQ = 8'h05;
  localparam logic [7:0] LEN_MAIL_REQ = 8'h1c;
  localparam logic [7:0] LEN_PAGE1 = 8'h16;
  localparam logic [7:0] LEN_MAIL_REPLY = 8'h10;
  localparam logic [7:0] LEN_EMPTY = 8'h00;
  // Status page selectors and page 1 contents.
  localparam logic [7:0] PAGE_CONNECT = 8'h00;
  localparam logic [7:0] PAGE_DISPLAY = 8'h01;
  localparam logic [7:0] PAGE_STATS = 8'h02;
  localparam logic [7:0] PAGE1_VERSION = 8'h00;
  localparam logic [7:0] CLEAN_NEEDED_CODE = 8'h01;
  localparam logic [7:0] CLEAN_IDLE_CODE = 8'h00;
  localparam int MAX_READ_BYTES = 64;
  // Library eject sequence.
  localparam logic [7:0] UNLOAD_BUTTON_SYMBOL = 8'heb;
  localparam logic [31:0] EJECT_TASK = 32'h0000_00e9;
  localparam logic [31:0] EJECT_MAIL = 32'h0000_00ea;
  localparam logic [31:0] EJECT_LINK = 32'h0000_0048;
  localparam logic [31:0] EJECT_ITER = 32'h0000_0001;
  localparam logic [31:0] EJECT_EXPECT = 32'h0000_0000;
  localparam logic [31:0] SYMBOL_READ_BYTES = 32'h0000_0004;
  // Word positions inside a packet (byte offset divided by four).
  localparam int W_HDR = 0;
  localparam int W_SUM = 1;
  localparam int W_FUNC = 2;
  localparam int W_ARG = 3;
  localparam int W_COUNT = 4;
  localparam int W_LINK = 5;
  localparam int W_PARAM = 6;
  localparam int W_ITER = 7;
  localparam int W_EXPECT = 8;
  localparam int HDR_WORDS = 2;
  localparam int RX_WORDS = 9;
  localparam int TX_WORDS = 18;
  // Byte counts of whole packets.
  localparam int RX_BYTES = 36;
  localparam int TX_BYTES = 72;
  localparam logic [6:0] HDR_BYTES = 7'd8;
  localparam logic [6:0] PAGE1_BYTES = 7'd32;
  localparam logic [6:0] MAIL_RPL_BYTES = 7'd24;
  localparam logic [5:0] RD_REQ_BYTES = 6'd20;
  localparam logic [5:0] ST_REQ_BYTES = 6'd13;
  localparam logic [5:0] ML_REQ_BYTES = 6'd36;
  // Library command codes.
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_STATUS = 2'b01,
    OP_EJECT = 2'b10
  } dsrr_op_e;

  // Builds word 0: length, reserved, type, channel.
  function automatic logic [31:0] hdr_word(input logic [7:0] len,
      input logic [7:0] typ, input logic [7:0] chan);
    hdr_word = {len, 8'h00, typ, chan};
  endfunction : hdr_word

  // Selects a byte of a word; byte 0 of a word travels first.
  function automatic logic [7:0] pick_byte(input logic [31:0] w,
      input logic [1:0] s);
    unique case (s)
      2'd0: pick_byte = w[31:24];
      2'd1: pick_byte = w[23:16];
      2'd2: pick_byte = w[15:8];
      2'd3: pick_byte = w[7:0];
    endcase
  endfunction : pick_byte
endpackage : dsrr_pkg

/* src/dsrr_link_if.sv */
// Byte stream link between the library controller and the drive.
`timescale 1ns/10ps
interface dsrr_link_if;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_data;
  logic req_last;
  logic rpl_valid;
  logic rpl_ready;
  logic [7:0] rpl_data;
  logic rpl_last;
  modport dev (
    input req_valid, req_data, req_last, rpl_ready,
    output req_ready, rpl_valid, rpl_data, rpl_last
  );
  modport lib (
    output req_valid, req_data, req_last, rpl_ready,
    input req_ready, rpl_valid, rpl_data, rpl_last
  );
endinterface : dsrr_link_if

/* src/dsrr_fifo.sv */
// Small valid/ready buffer that decouples the reply stream from the link.
`timescale 1ns/10ps
module dsrr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire logic full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire logic empty = (wp == rp);
  wire logic push = in_valid && !full;
  wire logic pop = out_valid && out_ready;

  // Full and empty come straight from the pointers, so no word is lost.
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];

  // Pointers carry one extra bit to tell full from empty.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end

  // Storage needs no reset; empty hides stale words.
  always_ff @(posedge clk) begin
    if (push) mem[wp[AW-1:0]] <= in_data;
  end
endmodule : dsrr_fifo

/* src/dsrr_library.sv */
// Library end: builds requests and runs the cartridge eject sequence.
`timescale 1ns/10ps
module dsrr_library
  import dsrr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  dsrr_link_if.lib LNK,
  input wire logic SYM_LOAD,
  input wire logic [31:0] SYM_BASE_IN,
  input wire logic [7:0] SYM_MAX_IN,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [1:0] CMD_OP,
  input wire logic [7:0] CMD_CHAN,
  input wire logic [31:0] CMD_ADDR,
  input wire logic [31:0] CMD_COUNT,
  input wire logic [7:0] CMD_PAGE,
  output logic CMD_ERR,
  output logic RSP_VALID,
  output logic RSP_OK,
  output logic [7:0] RSP_LEN,
  input wire logic [4:0] RSP_SEL,
  output logic [31:0] RSP_WORD
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b10,
    H_CHECK = 2'b11
  } dsrr_lib_state_e;

  dsrr_lib_state_e state;
  logic [31:0] q [RX_WORDS];
  logic [31:0] r [TX_WORDS];
  logic [31:0] qsum;
  logic [31:0] rsum;
  logic [31:0] sym_base;
  logic [7:0] sym_max;
  logic [7:0] chan;
  logic [5:0] nq;
  logic [5:0] qi;
  logic [6:0] rb;
  logic ejph;

  // Command screening before anything is sent.
  wire logic acc = CMD_VALID && CMD_READY;
  wire logic cmd_bad = (CMD_OP == OP_EJECT &&
      UNLOAD_BUTTON_SYMBOL > sym_max) ||
      (CMD_OP == OP_READ && CMD_COUNT > 32'(MAX_READ_BYTES)) ||
      (CMD_OP == 2'b11);
  wire logic build = acc && !cmd_bad;
  wire logic [31:0] sym_addr = sym_base +
      {22'h0, UNLOAD_BUTTON_SYMBOL, 2'b00};
  assign CMD_READY = (state == H_IDLE);

  // Reply reception and its checks.
  wire logic rx_fire = LNK.rpl_valid && LNK.rpl_ready;
  wire logic rx_in = rx_fire && (rb < 7'(TX_BYTES));
  wire logic [4:0] rwi = rb[6:2];
  wire logic [31:0] rx_word = {r[rwi][23:0], LNK.rpl_data};
  wire logic rsp_ok = (rsum == r[W_SUM]) &&
      (r[W_HDR][15:8] == END_OF_REPLY_TYPE) &&
      (r[W_HDR][7:0] == chan);
  wire logic mail_go = (state == H_CHECK) && ejph && rsp_ok;
  assign LNK.rpl_ready = (state == H_WAIT);
  assign RSP_WORD = (RSP_SEL < 5'(TX_WORDS)) ? r[RSP_SEL] : 32'h0;

  // Request stream; word 1 is replaced by the checksum qsum, summed combinationally over the stored words.
  wire logic [3:0] qwi = qi[5:2];
  wire logic [31:0] q_word = (qwi == 4'(W_SUM)) ? qsum : q[qwi];
  assign LNK.req_valid = (state == H_SEND);
  assign LNK.req_data = pick_byte(q_word, qi[1:0]);
  assign LNK.req_last = (qi == nq - 6'd1);

  // Checksum over every request word but the checksum itself.
  always_comb begin
    qsum = '0;
    for (int i = 0; i < RX_WORDS; i++) begin
      if (i != W_SUM) qsum = qsum + q[i];
    end
  end

  // Control: send, wait, check, and chain the eject mail.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state <= H_IDLE;
      sym_base <= '0;
      sym_max <= '0;
      chan <= '0;
      nq <= '0;
      qi <= '0;
      rb <= '0;
      rsum <= '0;
      ejph <= 1'b0;
      CMD_ERR <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_OK <= 1'b0;
      RSP_LEN <= '0;
    end else begin
      CMD_ERR <= 1'b0;
      RSP_VALID <= 1'b0;
      if (SYM_LOAD) begin
        sym_base <= SYM_BASE_IN;
        sym_max <= SYM_MAX_IN;
      end
      unique case (state)
        H_IDLE: begin
          if (acc && cmd_bad) CMD_ERR <= 1'b1;
          if (build) begin
            chan <= CMD_CHAN;
            ejph <= (CMD_OP == OP_EJECT);
            nq <= (CMD_OP == OP_STATUS) ? ST_REQ_BYTES : RD_REQ_BYTES;
            qi <= '0;
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (LNK.req_ready) begin
            qi <= qi + 6'd1;
            if (LNK.req_last) begin
              rb <= '0;
              rsum <= '0;
              state <= H_WAIT;
            end
          end
        end
        H_WAIT: begin
          if (rx_in && rb[1:0] == 2'd3 && rwi != 5'(W_SUM)) begin
            rsum <= rsum + rx_word;
          end
          if (rx_fire && rb < 7'd127) rb <= rb + 7'd1;
          if (rx_fire && LNK.rpl_last) state <= H_CHECK;
        end
        H_CHECK: begin
          ejph <= 1'b0;
          if (mail_go) begin
            nq <= ML_REQ_BYTES;
            qi <= '0;
            state <= H_SEND;
          end else begin
            RSP_VALID <= 1'b1;
            RSP_OK <= rsp_ok;
            RSP_LEN <= r[W_HDR][31:24];
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Request and reply words.
  always_ff @(posedge CLK_SYS) begin
    if (build) begin
      for (int i = 0; i < RX_WORDS; i++) begin
        q[i] <= '0;
      end
      if (CMD_OP == OP_STATUS) begin
        q[W_HDR] <= hdr_word(LEN_STATUS_REQ, TYPE_REQUEST, CMD_CHAN);
        q[W_FUNC] <= STATUS_PAGE_FUNCTION;
        q[W_ARG] <= {CMD_PAGE, 24'h0};
      end else begin
        q[W_HDR] <= hdr_word(LEN_READ_REQ, TYPE_REQUEST, CMD_CHAN);
        q[W_FUNC] <= MEMORY_BLOCK_READ_FUNCTION;
        q[W_ARG] <= (CMD_OP == OP_EJECT) ? sym_addr : CMD_ADDR;
        q[W_COUNT] <= (CMD_OP == OP_EJECT) ?
            SYMBOL_READ_BYTES : CMD_COUNT;
      end
    end else if (mail_go) begin
      q[W_HDR] <= hdr_word(LEN_MAIL_REQ, TYPE_REQUEST, chan);
      q[W_FUNC] <= TASK_SCHEDULE_FUNCTION;
      q[W_ARG] <= EJECT_TASK;
      q[W_COUNT] <= EJECT_MAIL;
      q[W_LINK] <= EJECT_LINK;
      q[W_PARAM] <= r[HDR_WORDS];
      q[W_ITER] <= EJECT_ITER;
      q[W_EXPECT] <= EJECT_EXPECT;
    end
    if (rx_in) begin
      r[rwi] <= (rb[1:0] == 2'd0) ? {24'h0, LNK.rpl_data} : rx_word;
    end
  end
endmodule : dsrr_library

/* testbench/dsrr_link_properties.sv */
// Wire-level checks on the request/reply link between the two ends.
`timescale 1ns/10ps
module dsrr_link_properties
  import dsrr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic rpl_valid,
  input wire logic rpl_ready,
  input wire logic [7:0] rpl_data,
  input wire logic rpl_last
);
  logic req_hs;
  logic rpl_hs;
  logic [6:0] req_idx;
  logic [6:0] rpl_idx;
  logic [7:0] req_chan;
  logic [7:0] rpl_len;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // A byte moves only when both valid and ready are high.
  assign req_hs = req_valid && req_ready;
  assign rpl_hs = rpl_valid && rpl_ready;
  // Byte positions; channel and length are kept to judge the reply.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      req_idx <= 7'h00;
      rpl_idx <= 7'h00;
      req_chan <= 8'h00;
      rpl_len <= 8'h00;
    end else begin
      if (req_hs) req_idx <= req_last ? 7'h00 : req_idx + 7'h01;
      if (rpl_hs) rpl_idx <= rpl_last ? 7'h00 : rpl_idx + 7'h01;
      if (req_hs && req_idx == 7'h03) req_chan <= req_data;
      if (rpl_hs && rpl_idx == 7'h00) rpl_len <= rpl_data;
    end
  end
  a_req_held: assert property (
    req_valid && !req_ready |=> req_valid && $stable({req_data, req_last}))
    else $error("request byte changed while stalled");
  a_rpl_held: assert property (
    rpl_valid && !rpl_ready |=> rpl_valid && $stable({rpl_data, rpl_last}))
    else $error("reply byte changed while stalled");
  a_req_type: assert property (
    req_hs && req_idx == 7'h02 |-> req_data == TYPE_REQUEST)
    else $error("request type byte wrong");
  a_rpl_type: assert property (
    rpl_hs && rpl_idx == 7'h02 |-> rpl_data == END_OF_REPLY_TYPE)
    else $error("reply type byte wrong");
  a_rpl_chan: assert property (
    rpl_hs && rpl_idx == 7'h03 |-> rpl_data == req_chan)
    else $error("reply channel differs from request");
  a_rpl_length: assert property (
    rpl_hs && rpl_last |->
    rpl_idx == ((rpl_len == LEN_PAGE1) ? 7'd31 : 7'd7 + rpl_len[6:0]))
    else $error("reply size does not match its length byte");
  a_page_version: assert property (
    rpl_hs && rpl_idx == 7'd8 && rpl_len == LEN_PAGE1
    |-> rpl_data == PAGE1_VERSION)
    else $error("page version byte wrong");
  a_text_null: assert property (
    rpl_hs && rpl_idx == 7'd28 && rpl_len == LEN_PAGE1 |-> rpl_data == 8'h00)
    else $error("display text not terminated");
  c_page1: cover property (rpl_hs && rpl_last && rpl_len == LEN_PAGE1);
  c_mail: cover property (rpl_hs && rpl_last && rpl_len == LEN_MAIL_REPLY);
  c_stall: cover property (req_valid && !req_ready);
endmodule : dsrr_link_properties

/* testbench/drive_serial_request_reply_test.sv */
// Both link ends joined, driven from the library command side.
`timescale 1ns/10ps
module drive_serial_request_reply_test
  import dsrr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sym_load = 1'b0;
  logic [31:0] sym_base = 32'h0;
  logic [7:0] sym_max = 8'h0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'b0;
  logic [7:0] cmd_chan = 8'h0;
  logic [31:0] cmd_addr = 32'h0;
  logic [31:0] cmd_count = 32'h0;
  logic [7:0] cmd_page = 8'h0;
  logic [4:0] rsp_sel = 5'h0;
  logic [5:0] cart = 6'h0;
  logic clean = 1'b0;
  logic [127:0] text = 128'h0;
  logic [7:0] temp = 8'h0;
  logic mem_rd, mail_req, bad_req, cmd_ready, cmd_err, rsp_valid, rsp_ok;
  logic [31:0] mem_addr, mem_rdata, mail_task, mail_cmd, mail_link;
  logic [31:0] mail_param, mail_iter, mail_expect, rsp_word;
  logic [7:0] rsp_len;
  int n_mismatch = 0;
  int tests_run = 0;
  dsrr_link_if lnk ();
  // Memory answers with the inverted address; mail completes at once.
  assign mem_rdata = ~mem_addr;
  always #25 clk = ~clk;
  dsrr_device #(.MAX_BYTES(MAX_READ_BYTES)) dsrr_device_i (.CLK_SYS(clk),
    .RST(rst), .LNK(lnk.dev), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
    .MEM_RDATA(mem_rdata), .CART_FLAGS(cart), .CLEAN_NEEDED(clean),
    .DISPLAY_TEXT(text), .TEMPERATURE(temp), .MAIL_REQ(mail_req),
    .MAIL_TASK(mail_task), .MAIL_CMD(mail_cmd), .MAIL_LINK(mail_link),
    .MAIL_PARAM(mail_param), .MAIL_ITER(mail_iter),
    .MAIL_EXPECT(mail_expect), .MAIL_DONE(mail_req),
    .MAIL_STATUS(32'h0), .MAIL_ITER_OK(32'h1), .BAD_REQ(bad_req));
  dsrr_library dsrr_library_i (.CLK_SYS(clk), .RST(rst), .LNK(lnk.lib),
    .SYM_LOAD(sym_load), .SYM_BASE_IN(sym_base), .SYM_MAX_IN(sym_max),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
    .CMD_CHAN(cmd_chan), .CMD_ADDR(cmd_addr), .CMD_COUNT(cmd_count),
    .CMD_PAGE(cmd_page), .CMD_ERR(cmd_err), .RSP_VALID(rsp_valid),
    .RSP_OK(rsp_ok), .RSP_LEN(rsp_len), .RSP_SEL(rsp_sel),
    .RSP_WORD(rsp_word));
  dsrr_link_properties dsrr_link_properties_i (.CLK_SYS(clk), .RST(rst),
    .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
    .req_data(lnk.req_data), .req_last(lnk.req_last),
    .rpl_valid(lnk.rpl_valid), .rpl_ready(lnk.rpl_ready),
    .rpl_data(lnk.rpl_data), .rpl_last(lnk.rpl_last));

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic word(input logic [4:0] s, input logic [31:0] exp);
    rsp_sel = s;
    #1 chk("reply word", rsp_word, exp);
  endtask : word

  // One command; returns once a reply or a refusal is seen.
  task automatic run(input logic [1:0] op, input logic [7:0] ch,
      input logic [31:0] a, input logic [31:0] n, input logic [7:0] pg);
    cmd_op = op;
    cmd_chan = ch;
    cmd_addr = a;
    cmd_count = n;
    cmd_page = pg;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    for (int k = 0; k < 3000; k++) begin
      if (rsp_valid === 1'b1 || cmd_err === 1'b1) break;
      @(posedge clk);
      #1;
    end
  endtask : run

  task automatic t_status;
    for (int i = 0; i < 2; i++) begin
      cart = i ? 6'h2d : 6'h12;
      clean = (i == 1);
      temp = 8'h20 + 8'(i);
      text = {8{16'h4142 + 16'(i)}};
      run(OP_STATUS, 8'h30, 32'h0, 32'h0, PAGE_DISPLAY);
      chk("page1 ok", {31'h0, rsp_ok}, 32'h1);
      chk("page1 length", {24'h0, rsp_len}, {24'h0, LEN_PAGE1});
      word(5'd0, {LEN_PAGE1, 8'h00, END_OF_REPLY_TYPE, 8'h30});
      word(5'd2, {PAGE1_VERSION, 8'h00, cart, 2'b00,
        clean ? CLEAN_NEEDED_CODE : CLEAN_IDLE_CODE});
      for (int k = 0; k < 4; k++) word(5'(3 + k), text[127 - 32*k -: 32]);
      rsp_sel = 5'd7;
      #1 chk("page1 tail", rsp_word & 32'hff00ff00, {16'h0, temp, 8'h0});
      run(OP_STATUS, 8'h41, 32'h0, 32'h0, i ? PAGE_STATS : PAGE_CONNECT);
      chk("empty page", {24'h0, rsp_len}, {24'h0, LEN_EMPTY});
      word(5'd0, {LEN_EMPTY, 8'h00, END_OF_REPLY_TYPE, 8'h41});
    end
    $display("Test status pages done");
  endtask : t_status

  task automatic t_read;
    run(OP_READ, 8'h05, 32'h0012_3450, 32'd64, 8'h0);
    chk("read length", {24'h0, rsp_len}, 32'h40);
    for (int k = 0; k < 16; k++) word(5'(2 + k), ~(32'h0012_3450 + 32'(4*k)));
    run(OP_READ, 8'h05, 32'h0012_3450, 32'd65, 8'h0);
    chk("oversize refused", {31'h0, cmd_err}, 32'h1);
    $display("Test memory read done");
  endtask : t_read

  task automatic t_eject;
    sym_base = 32'h001d_f32c;
    for (int i = 0; i < 2; i++) begin
      sym_max = i ? 8'hea : 8'hff;
      sym_load = 1'b1;
      @(posedge clk);
      #1 sym_load = 1'b0;
      run(OP_EJECT, 8'h04, 32'h0, 32'h0, 8'h0);
      chk("eject refused", {31'h0, cmd_err}, 32'(i));
    end
    sym_max = 8'hff;
    sym_load = 1'b1;
    @(posedge clk);
    #1 sym_load = 1'b0;
    run(OP_EJECT, 8'h04, 32'h0, 32'h0, 8'h0);
    chk("mail task", mail_task, EJECT_TASK);
    chk("mail command", mail_cmd, EJECT_MAIL);
    chk("mail link", mail_link, EJECT_LINK);
    chk("mail param", mail_param, ~32'h001d_f6d8);
    chk("mail iter", mail_iter, EJECT_ITER);
    chk("mail expect", mail_expect, EJECT_EXPECT);
    chk("mail length", {24'h0, rsp_len}, {24'h0, LEN_MAIL_REPLY});
    word(5'd0, {LEN_MAIL_REPLY, 8'h00, END_OF_REPLY_TYPE, 8'h04});
    run(2'b11, 8'h04, 32'h0, 32'h0, 8'h0);
    chk("illegal op", {31'h0, cmd_err}, 32'h1);
    $display("Test eject done");
  endtask : t_eject

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_status;
    t_read;
    t_eject;
    end_sim;
  end

  // Whole run needs well under 3000 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
endmodule : drive_serial_request_reply_test
